// File: design/ivt_pkg.sv
// Constants, types and register map of the twelve-bit interval timer
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package ivt_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [19:0] IDX_OPTION = 20'hF00F3;
  localparam logic [19:0] IDX_GATE   = 20'hF00FC;
  localparam logic [19:0] IDX_SRESET = 20'hF00FD;
  localparam logic [19:0] IDX_CTRL   = 20'hFFF90;

  // Field positions
  localparam int unsigned POS_RUN     = 15;
  localparam int unsigned POS_CKSEL   = 4;
  localparam int unsigned POS_TIMER   = 7;
  localparam int unsigned CMP_W       = 12;

  // Reset values and writable masks
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [11:0] RST_CMP     = 12'hFFF;
  localparam logic [11:0] CNT_ZERO    = 12'h000;
  localparam logic [11:0] CNT_ONE     = 12'h001;
  localparam logic [7:0]  MASK_OPTION = 8'h90;
  localparam logic [7:0]  MASK_GATE   = 8'hF5;
  localparam logic [7:0]  MASK_SRESET = 8'hF4;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

  // Bus encodings
  localparam logic [2:0]  HSIZE_HALF  = 3'h1;
  localparam logic        HRESP_OKAY  = 1'b0;

  // Captured address phase
  typedef struct packed {
    logic        ok;
    logic [19:0] idx;
    logic        write;
    logic [2:0]  size;
  } ivt_aphase_t;

  // Bus slave states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WR    = 4'b0010,
    ST_RD    = 4'b0100,
    ST_RDOUT = 4'b1000
  } ivt_bus_state_t;

endpackage

// File: design/ivt_rise_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module ivt_rise_sync
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic pin,
  output logic      rise
);
  import ivt_pkg::*;

  logic [2:0] sync_reg;
  logic       level_reg;
  logic       agree;

  // Stage one feeds stage two only
  assign agree = (sync_reg[1] == sync_reg[2]);
  assign rise  = agree & sync_reg[2] & ~level_reg;

  // Shift chain and filtered level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
    end
    else if (ce)
    begin
      sync_reg  <= {sync_reg[1:0], pin};
      if (agree)
        level_reg <= sync_reg[2];
    end
  end
endmodule // ivt_rise_sync
`default_nettype wire

// File: design/ivt_timer.sv
// Twelve-bit interval timer with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module ivt_timer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        subclk_pin,
  input  wire logic        loco_pin,
  output logic             loco_enable,
  output logic             interval_irq
);
  import ivt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  ivt_bus_state_t state_reg;
  ivt_bus_state_t state_next;
  ivt_aphase_t    aph_reg;
  ivt_aphase_t    aph_now;
  logic [31:0]    hrdata_reg;
  logic [31:0]    rd_mux;
  logic [7:0]     option_reg;
  logic [7:0]     gate_reg;
  logic [7:0]     sreset_reg;
  logic [11:0]    cmp_reg;
  logic           run_req_reg;
  logic           pend_reg;
  logic           run_act_reg;
  logic [11:0]    cmp_act_reg;
  logic [11:0]    cnt_reg;
  logic           irq_reg;
  logic           aphase_take;
  logic           in_wr;
  logic           in_rd;
  logic           we_option;
  logic           we_gate;
  logic           we_sreset;
  logic           we_ctrl;
  logic           clock_gate;
  logic           soft_reset;
  logic           count_clock_select;
  logic           tick;
  logic           match;
  logic           stop_now;
  logic [1:0]     count_pins;
  logic [1:0]     count_rise;

  // Address-phase decode check shared by writes and reads
  function automatic logic hit(input ivt_aphase_t a, input logic [19:0] idx);
    hit = a.ok && (a.idx == idx);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero-wait writes, reads with one wait state

  // Address-phase capture
  assign aphase_take   = hsel & hready & htrans[1];
  assign aph_now.ok    = (haddr[1:0] == 2'h0) && (haddr[31:22] == 10'h000);
  assign aph_now.idx   = haddr[21:2];
  assign aph_now.write = hwrite;
  assign aph_now.size  = hsize;

  // Handshake outputs
  assign in_wr     = (state_reg == ST_WR);
  assign in_rd     = (state_reg == ST_RD);
  assign hreadyout = ~in_rd;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_reg;

  // Next bus state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RD:
        state_next = ST_RDOUT;
      ST_IDLE, ST_WR, ST_RDOUT:
        if (!hready)
          state_next = state_reg;
        else if (aphase_take)
          state_next = hwrite ? ST_WR : ST_RD;
        else
          state_next = ST_IDLE;
    endcase
  end

  // Bus state and captured phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      aph_reg   <= '0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      if (aphase_take && !in_rd)
        aph_reg <= aph_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Write strobes; timer control only when clocked, out of reset, half word or wider
  assign we_option = in_wr & hit(aph_reg, IDX_OPTION);
  assign we_gate   = in_wr & hit(aph_reg, IDX_GATE);
  assign we_sreset = in_wr & hit(aph_reg, IDX_SRESET);
  assign we_ctrl   = in_wr & hit(aph_reg, IDX_CTRL) & clock_gate & ~soft_reset
                     & (aph_reg.size >= HSIZE_HALF);

  // Named control bits
  assign clock_gate         = gate_reg[POS_TIMER];
  assign soft_reset         = sreset_reg[POS_TIMER];
  assign count_clock_select = option_reg[POS_CKSEL];
  assign loco_enable        = count_clock_select;

  // Shared byte registers, unused bits held at zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      option_reg <= RST_BYTE;
      gate_reg   <= RST_BYTE;
      sreset_reg <= RST_BYTE;
    end
    else if (ce)
    begin
      if (we_option)
        option_reg <= hwdata[7:0] & MASK_OPTION;
      if (we_gate)
        gate_reg <= hwdata[7:0] & MASK_GATE;
      if (we_sreset)
        sreset_reg <= hwdata[7:0] & MASK_SRESET;
    end
  end

  // Bus-side control word; soft reset holds it at its reset value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_reg     <= RST_CMP;
      run_req_reg <= 1'b0;
      pend_reg    <= 1'b0;
    end
    else if (ce)
    begin
      if (soft_reset)
      begin
        cmp_reg     <= RST_CMP;
        run_req_reg <= 1'b0;
        pend_reg    <= 1'b0;
      end
      else if (we_ctrl)
      begin
        cmp_reg     <= hwdata[CMP_W-1:0];
        run_req_reg <= hwdata[POS_RUN];
        pend_reg    <= 1'b1;
      end
      else if (tick)
        pend_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Read mux; gated timer reads zero, reserved bits zero
  assign rd_mux = hit(aph_reg, IDX_OPTION) ? {24'h000000, option_reg} :
                  hit(aph_reg, IDX_GATE)   ? {24'h000000, gate_reg}   :
                  hit(aph_reg, IDX_SRESET) ? {24'h000000, sreset_reg} :
                  (hit(aph_reg, IDX_CTRL) && clock_gate)
                    ? {16'h0000, run_act_reg, 3'h0, cmp_reg} : RD_ZERO;

  // Read data taken in the wait cycle, after any preceding write landed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= RD_ZERO;
    else if (ce && in_rd)
      hrdata_reg <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Count clock: pins synchronised, selected and gated

  assign count_pins = {loco_pin, subclk_pin};

  // One synchroniser per count-clock pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      ivt_rise_sync u_sync
      (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .pin     (count_pins[gi]),
        .rise    (count_rise[gi])
      );
    end
  endgenerate

  // Tick per selected count-clock cycle, only while clocked and released
  assign tick = clock_gate & ~soft_reset
                & count_rise[count_clock_select];

  //////////////////////////////////////////////////////////////////////////////
  // Counter, compare and interrupt

  assign match        = run_act_reg && (cnt_reg == cmp_act_reg);
  assign stop_now     = pend_reg & ~run_req_reg;
  assign interval_irq = irq_reg;

  // Count-side state; advances on pin ticks but is clocked by hclk, so it freezes while ce is low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_act_reg <= 1'b0;
      cmp_act_reg <= RST_CMP;
      cnt_reg     <= CNT_ZERO;
      irq_reg     <= 1'b0;
    end
    else if (ce)
    begin
      if (soft_reset)
      begin
        run_act_reg <= 1'b0;
        cmp_act_reg <= RST_CMP;
        cnt_reg     <= CNT_ZERO;
        irq_reg     <= 1'b0;
      end
      else if (tick)
      begin
        if (pend_reg)
        begin
          run_act_reg <= run_req_reg;
          cmp_act_reg <= cmp_reg;
        end
        if (!run_act_reg || stop_now)
          cnt_reg <= CNT_ZERO;
        else if (match)
          cnt_reg <= CNT_ZERO;
        else
          cnt_reg <= cnt_reg + CNT_ONE;
        irq_reg <= match;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_count_step;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && run_act_reg && !match && !stop_now
      |=> cnt_reg == 12'($past(cnt_reg) + CNT_ONE);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_match_wrap;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && match |=> cnt_reg == CNT_ZERO && interval_irq;
  endproperty
  a_match_wrap: assert property (p_match_wrap) else $error("match did not wrap");

  property p_irq_cause;
    @(posedge hclk) disable iff (!hresetn)
    $rose(interval_irq) |-> $past(cnt_reg) == $past(cmp_act_reg) && $past(run_act_reg);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without match");

  property p_stop_clear;
    @(posedge hclk) disable iff (!hresetn)
    ce && !run_act_reg |=> cnt_reg == CNT_ZERO;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not zero");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
    ce && in_rd && hit(aph_reg, IDX_CTRL) |=> hrdata[14:12] == 3'h0 && hrdata[31:16] == 16'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_gated_read;
    @(posedge hclk) disable iff (!hresetn)
    ce && in_rd && hit(aph_reg, IDX_CTRL) && !clock_gate |=> hrdata == RD_ZERO;
  endproperty
  a_gated_read: assert property (p_gated_read) else $error("gated read not zero");

  property p_run_delay;
    @(posedge hclk) disable iff (!hresetn)
    ce && we_ctrl && !tick |=> run_act_reg == $past(run_act_reg);
  endproperty
  a_run_delay: assert property (p_run_delay) else $error("run flag applied early");

  property p_soft_reset;
    @(posedge hclk) disable iff (!hresetn)
    ce && soft_reset |=> !run_act_reg && cnt_reg == CNT_ZERO && !interval_irq;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not held");

  property p_irq_pulse;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && interval_irq && !match |=> !interval_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    in_rd |-> !hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait missing");

  property p_ctrl_size;
    @(posedge hclk) disable iff (!hresetn)
    ce && in_wr && hit(aph_reg, IDX_CTRL) && (aph_reg.size < HSIZE_HALF) && !soft_reset
      |=> cmp_reg == $past(cmp_reg) && run_req_reg == $past(run_req_reg);
  endproperty
  a_ctrl_size: assert property (p_ctrl_size) else $error("narrow control write landed");

  property p_gated_write;
    @(posedge hclk) disable iff (!hresetn)
    ce && in_wr && hit(aph_reg, IDX_CTRL) && !clock_gate && !soft_reset
      |=> cmp_reg == $past(cmp_reg) && run_req_reg == $past(run_req_reg);
  endproperty
  a_gated_write: assert property (p_gated_write) else $error("gated write landed");

  property p_run_apply;
    @(posedge hclk) disable iff (!hresetn)
    ce && tick && pend_reg
      |=> run_act_reg == $past(run_req_reg) && cmp_act_reg == $past(cmp_reg);
  endproperty
  a_run_apply: assert property (p_run_apply) else $error("control word not applied");

  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(interval_irq));
  c_start: cover property (@(posedge hclk) disable iff (!hresetn) $rose(run_act_reg));
  c_stop: cover property (@(posedge hclk) disable iff (!hresetn) $fell(run_act_reg));
  c_loco: cover property (@(posedge hclk) disable iff (!hresetn) tick && count_clock_select);

endmodule // ivt_timer
`default_nettype wire

// File: test/ivt_timer_bench.sv
// Self-checking bench of the twelve-bit interval timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module ivt_timer_bench;
  import ivt_pkg::*;

  typedef struct packed {
    logic [31:0] a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } ivt_row_t;

  // Byte addresses of the register words
  localparam logic [31:0] A_OPT  = {10'h000, IDX_OPTION, 2'b00};
  localparam logic [31:0] A_GATE = {10'h000, IDX_GATE, 2'b00};
  localparam logic [31:0] A_SRST = {10'h000, IDX_SRESET, 2'b00};
  localparam logic [31:0] A_CTRL = {10'h000, IDX_CTRL, 2'b00};
  localparam logic [31:0] A_BAD  = 32'h0000_0100;

  logic        hclk, hresetn, ce, hsel, hwrite, subclk_pin, loco_pin;
  logic        hreadyout, hresp, loco_enable, interval_irq, irq_d, use_loco, watch;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  wire         hready;
  int          err_total, samples_checked, rises, hi_cnt, exp_per;
  time         last_t;
  ivt_row_t    rows [15];

  // One slave, so its ready is the bus ready
  assign hready = hreadyout;

  ivt_timer uut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .subclk_pin(subclk_pin), .loco_pin(loco_pin), .loco_enable(loco_enable),
    .interval_irq(interval_irq)
  );

  ////////////////////////////////////////////////////////////////////
  // 125 MHz bus clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Interrupt watcher: spacing of rising edges and pulse width
  always @(posedge hclk)
  begin
    irq_d <= interval_irq;
    if (watch && interval_irq === 1'b1 && irq_d === 1'b0)
    begin
      rises++;
      if (last_t != 0) `CHK($time - last_t, exp_per * 64)
      last_t = $time;
      hi_cnt = 1;
    end
    else if (interval_irq === 1'b1)
      hi_cnt++;
    if (watch && last_t != 0 && interval_irq === 1'b0 && irq_d === 1'b1) `CHK(hi_cnt, 8)
  end

  ////////////////////////////////////////////////////////////////////
  // Single word transfer; waits on hready under a bound
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge hclk);
    end
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge hclk);
    end
    r = hrdata;
    `CHK(hresp, HRESP_OKAY)
    if (n >= 20) `CHK(1'b0, 1'b1)
  endtask

  // Count-clock cycles on the chosen pin, 8 bus clocks each
  task automatic tick(input int n);
    repeat (n)
    begin
      if (use_loco) loco_pin <= 1'b1;
      else subclk_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      subclk_pin <= 1'b0;
      loco_pin   <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask

  // Run n count cycles and count interrupt pulses
  task automatic run(input int per, input int n, input int exp_r);
    exp_per = per;
    last_t  = 0;
    rises   = 0;
    watch   = 1'b1;
    tick(n);
    watch   = 1'b0;
    `CHK(rises, exp_r)
  endtask

  // Verdict
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = '0; subclk_pin = 1'b0;
    loco_pin = 1'b0; use_loco = 1'b0; exp_per = 0; last_t = 0; rises = 0; watch = 1'b0;
    rows = '{'{A_OPT, 1'b0, 32'h0, 32'h0}, '{A_GATE, 1'b0, 32'h0, 32'h0},
             '{A_SRST, 1'b0, 32'h0, 32'h0}, '{A_CTRL, 1'b0, 32'h0, 32'h0},
             '{A_CTRL, 1'b1, 32'h123, 32'h0}, '{A_GATE, 1'b1, 32'hFF, 32'h0},
             '{A_GATE, 1'b0, 32'h0, 32'hF5}, '{A_CTRL, 1'b0, 32'h0, 32'hFFF},
             '{A_SRST, 1'b1, 32'hFF, 32'h0}, '{A_SRST, 1'b0, 32'h0, 32'hF4},
             '{A_SRST, 1'b1, 32'h0, 32'h0}, '{A_OPT, 1'b1, 32'h80, 32'h0},
             '{A_OPT, 1'b0, 32'h0, 32'h80}, '{A_BAD, 1'b1, 32'hFF, 32'h0},
             '{A_BAD, 1'b0, 32'h0, 32'h0}};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(hreadyout, 1'b1)
    `CHK(loco_enable, 1'b0)
    `CHK(interval_irq, 1'b0)
    foreach (rows[i])
    begin
      bus(rows[i].a, rows[i].w, rows[i].d, rd);
      if (!rows[i].w) `CHK(rd, rows[i].e)
    end
    // Reserved bits of the control word
    bus(A_CTRL, 1'b1, 32'h0000_7ABC, rd);
    tick(2);
    bus(A_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0000_0ABC)
    // Start: run bit shows only after a count cycle, then period 4
    bus(A_CTRL, 1'b1, 32'h0000_8003, rd);
    bus(A_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd[15], 1'b0)
    tick(1);
    bus(A_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0000_8003)
    run(4, 21, 5);
    // Stop clears and halts
    bus(A_CTRL, 1'b1, 32'h0, rd);
    run(0, 11, 0);
    bus(A_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0)
    // Boundary compare values, restart from zero
    bus(A_CTRL, 1'b1, 32'h0000_8001, rd);
    run(2, 8, 3);
    bus(A_CTRL, 1'b1, 32'h0000_0FFF, rd);
    tick(1);
    bus(A_CTRL, 1'b1, 32'h0000_8FFF, rd);
    run(4096, 8194, 2);
    // Soft reset holds the timer
    bus(A_SRST, 1'b1, 32'h0000_0080, rd);
    run(0, 4, 0);
    bus(A_CTRL, 1'b1, 32'h0000_8002, rd);
    tick(2);
    bus(A_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0000_0FFF)
    bus(A_SRST, 1'b1, 32'h0, rd);
    // Oscillator clock selected; sub clock then ignored
    bus(A_OPT, 1'b1, 32'h0000_0010, rd);
    repeat (2) @(posedge hclk);
    `CHK(loco_enable, 1'b1)
    bus(A_CTRL, 1'b1, 32'h0000_8001, rd);
    use_loco = 1'b1;
    run(2, 8, 3);
    use_loco = 1'b0;
    run(0, 6, 0);
    // Clock enable low freezes the running count side
    use_loco = 1'b1;
    ce <= 1'b0;
    run(0, 4, 0);
    ce <= 1'b1;
    // Gate off hides and protects the stopped control word
    use_loco = 1'b1;
    bus(A_CTRL, 1'b1, 32'h0000_0005, rd);
    tick(1);
    bus(A_GATE, 1'b1, 32'h0, rd);
    bus(A_CTRL, 1'b1, 32'h0000_0123, rd);
    bus(A_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0)
    bus(A_GATE, 1'b1, 32'h0000_0080, rd);
    bus(A_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0000_0005)
    // Byte-wide write to the control word is ignored
    hsize <= 3'h0;
    bus(A_CTRL, 1'b1, 32'h0000_0007, rd);
    hsize <= 3'h2;
    bus(A_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0000_0005)
    bus(A_OPT, 1'b1, 32'h0, rd);
    repeat (2) @(posedge hclk);
    `CHK(loco_enable, 1'b0)
    results();
  end

  // Watchdog against a hang; the whole sequence needs about 530 us
  initial
  begin
    #700_000;
    err_total++;
    results();
  end

endmodule // ivt_timer_bench
`default_nettype wire
